/* File: design/iaso_top.sv */
// Ignition auto switch-off sequencer: state machine, timers, host ports
`default_nettype none
module iaso_top #(
  parameter int unsigned TICK_CYCLES = iaso_pkg::TICK_CYC,
  parameter int unsigned BIT_CYCLES = iaso_pkg::BAUD_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Sense pins
  input wire logic ign_i,
  input wire logic temp_crit_i,
  input wire logic self_ok_i,
  // Host parallel I/O cycle
  input wire logic [9:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Serial configuration line
  input wire logic cfg_rxd_i,
  // Power control
  output logic pwr_en_o,
  output logic boot_en_o
);
  import iaso_pkg::*;

  logic ign_s;
  logic hot_s;
  logic ok_s;
  logic rxd_s;
  logic rxd_n_s;
  logic [7:0] rx_data;
  logic rx_valid;
  iaso_state_t state;
  logic [31:0] div;
  logic tick;
  logic [15:0] tcnt;
  logic [15:0] delay_cfg;
  logic [15:0] shut_cfg;
  logic [1:0] cfg_phase;
  logic [7:0] cfg_cmd;
  logic [7:0] cfg_lo;
  logic host_done;
  logic host_alive;
  logic io_rd_q;
  logic io_wr_q;
  logic rd_edge;
  logic wr_edge;
  logic [7:0] status;

  // Pins from outside the clock domain
  iaso_sync u_ign (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(ign_i), .q_o(ign_s));
  iaso_sync u_hot (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(temp_crit_i), .q_o(hot_s));
  iaso_sync u_ok (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(self_ok_i), .q_o(ok_s));
  iaso_sync u_rxd (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(~cfg_rxd_i), .q_o(rxd_n_s));
  iaso_sync u_rd (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(io_rd_i), .q_o(io_rd_q));
  iaso_sync u_wr (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(io_wr_i), .q_o(io_wr_q));

  // Serial line is synchronised inverted, so its reset value reads as idle and not as a start bit
  assign rxd_s = ~rxd_n_s;

  // Configuration receiver at the configured bit rate
  iaso_uart_rx #(.BIT_CYC(BIT_CYCLES)) u_rx (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .rxd_i(rxd_s),
    .data_o(rx_data),
    .valid_o(rx_valid)
  );

  // Time base divider gives one-cycle tick
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (div == TICK_CYCLES - 1);
      div <= (div == TICK_CYCLES - 1) ? 32'h0 : div + 32'h1;
    end
  end

  // Serial command, low byte, high byte sets a time
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_phase <= 2'h0;
      cfg_cmd <= 8'h00;
      cfg_lo <= 8'h00;
      delay_cfg <= DELAY_RST;
      shut_cfg <= SHUT_RST;
    end else if (rx_valid) begin // R9
      case (cfg_phase)
        2'h0: begin
          cfg_cmd <= rx_data;
          if (rx_data == CMD_DELAY || rx_data == CMD_SHUT) begin
            cfg_phase <= 2'h1;
          end
        end
        2'h1: begin
          cfg_lo <= rx_data;
          cfg_phase <= 2'h2;
        end
        default: begin
          cfg_phase <= 2'h0;
          if (cfg_cmd == CMD_DELAY) begin
            delay_cfg <= {rx_data, cfg_lo}; // R11
          end else begin
            shut_cfg <= {rx_data, cfg_lo}; // R11
          end
        end
      endcase
    end
  end

  // Host port strobes on the rising edge of the synchronised strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_edge <= 1'b0;
      wr_edge <= 1'b0;
    end else begin
      rd_edge <= io_rd_q;
      wr_edge <= io_wr_q;
    end
  end

  // Control port write; done is a request, consumed on leaving shutdown
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_done <= 1'b0;
      host_alive <= 1'b0;
    end else begin
      if (io_wr_q && !wr_edge && io_addr_i == ADDR_CTRL) begin // R8
        host_alive <= io_wdata_i[CT_ALIVE];
        host_done <= io_wdata_i[CT_DONE] && (state == IASO_SHUT || state == IASO_HOT);
      end else if (state != IASO_SHUT && state != IASO_HOT) begin
        host_done <= 1'b0;
      end
    end
  end

  // Status byte and readback
  always_comb begin
    status = 8'h00;
    status[ST_SHUT_REQ] = (state == IASO_SHUT);
    status[ST_DELAY] = (state == IASO_DELAY);
    status[ST_HOT] = hot_s;
    status[ST_MASK] = (state == IASO_MASK);
    status[ST_IGN] = ign_s;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_q && !rd_edge) begin
      if (io_addr_i == ADDR_STATUS) begin // R8
        io_rdata_o <= status;
      end else if (io_addr_i == ADDR_CTRL) begin
        io_rdata_o <= {6'h00, host_alive, host_done};
      end else begin
        io_rdata_o <= 8'h00;
      end
    end
  end

  // Sequencer with shared tick counter
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= IASO_CHECK;
      tcnt <= 16'h0000;
    end else begin
      case (state)
        IASO_CHECK: begin
          if (ok_s && !hot_s) begin // R1
            state <= IASO_MASK;
            tcnt <= MASK_TICKS;
          end
        end
        IASO_MASK: begin
          if (tick) begin // R2
            if (tcnt <= 16'h0001) begin
              state <= IASO_RUN;
            end else begin
              tcnt <= tcnt - 16'h0001;
            end
          end
        end
        IASO_RUN: begin
          if (hot_s) begin // R3 R4
            state <= IASO_HOT;
            tcnt <= shut_cfg;
          end else if (!ign_s) begin // R5
            state <= IASO_DELAY;
            tcnt <= delay_cfg; // R11
          end
        end
        IASO_DELAY: begin
          if (hot_s) begin // R4
            state <= IASO_HOT;
            tcnt <= shut_cfg;
          end else if (ign_s) begin // R6
            state <= IASO_RUN;
          end else if (tick) begin
            if (tcnt <= 16'h0001) begin // R7
              state <= IASO_SHUT;
              tcnt <= shut_cfg;
            end else begin
              tcnt <= tcnt - 16'h0001;
            end
          end
        end
        IASO_SHUT: begin
          if (host_done) begin // R7
            state <= IASO_OFF;
          end else if (tick) begin
            if (tcnt <= 16'h0001) begin // R10
              state <= IASO_OFF;
            end else begin
              tcnt <= tcnt - 16'h0001;
            end
          end
        end
        IASO_HOT: begin
          if (host_done || (tick && tcnt <= 16'h0001)) begin // R4
            state <= IASO_OFF;
          end else if (tick) begin
            tcnt <= tcnt - 16'h0001;
          end
        end
        IASO_OFF: begin
          // Power stays off; cool with ignition on restarts the checks
          if (!hot_s && ign_s) begin // R4
            state <= IASO_CHECK;
          end
        end
        default: begin
          state <= IASO_CHECK;
        end
      endcase
    end
  end

  // Power and boot outputs from flip-flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_en_o <= 1'b0;
      boot_en_o <= 1'b0;
    end else begin
      pwr_en_o <= (state != IASO_OFF) && (state != IASO_CHECK || ok_s); // R7
      boot_en_o <= (state != IASO_CHECK) && (state != IASO_OFF); // R1
    end
  end

  // Assertions
  sequence s_delay_entry;
    state == IASO_RUN && !hot_s && !ign_s;
  endsequence

  sequence s_checks_pass;
    state == IASO_CHECK && ok_s && !hot_s;
  endsequence

  sequence s_delay_expiry;
    state == IASO_DELAY && !hot_s && !ign_s && tick && tcnt <= 16'h0001;
  endsequence

  sequence s_cool_restart;
    state == IASO_OFF && !hot_s && ign_s;
  endsequence

  a_boot_after_check: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R1
    state == IASO_CHECK |=> !boot_en_o)
    else $error("boot released during check");
  a_check_release: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R1
    s_checks_pass |=> state == IASO_MASK && tcnt == MASK_TICKS)
    else $error("checks passed but mask not started");
  a_mask_ignores_ign: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R2
    state == IASO_MASK && !tick |=> state == IASO_MASK)
    else $error("mask left early");
  a_run_watches: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R3
    state == IASO_RUN && hot_s |=> state == IASO_HOT)
    else $error("hot not seen in run");
  a_off_while_hot: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R4
    state == IASO_OFF && hot_s |=> state == IASO_OFF ##1 !pwr_en_o)
    else $error("power back while hot");
  a_hot_timeout: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R4
    state == IASO_HOT && tick && tcnt <= 16'h0001 |=> state == IASO_OFF)
    else $error("hot shutdown time not enforced");
  a_cool_restart: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R4
    s_cool_restart |=> state == IASO_CHECK)
    else $error("no restart after cooling");
  a_delay_enter: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R5
    s_delay_entry |=> state == IASO_DELAY && tcnt == delay_cfg)
    else $error("delay not entered with reload");
  a_delay_cancel: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R6
    state == IASO_DELAY && ign_s && !hot_s |=> state == IASO_RUN)
    else $error("delay not cancelled");
  a_delay_expiry: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
    s_delay_expiry |=> state == IASO_SHUT && tcnt == shut_cfg)
    else $error("delay expiry did not request shutdown");
  a_done_cuts: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
    state == IASO_SHUT && host_done |=> state == IASO_OFF ##1 !pwr_en_o)
    else $error("host done did not cut power");
  a_off_no_power: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
    state == IASO_OFF |=> !pwr_en_o)
    else $error("power on while off");
  a_done_refused: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R8
    state != IASO_SHUT && state != IASO_HOT |=> !host_done)
    else $error("done taken outside shutdown");
  a_power_during_delay: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R5
    state == IASO_DELAY |=> pwr_en_o)
    else $error("power lost during delay");
  a_shut_timeout: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
    state == IASO_SHUT && tick && tcnt <= 16'h0001 |=> state == IASO_OFF)
    else $error("shutdown time not enforced");
endmodule : iaso_top
`default_nettype wire

/* File: design/iaso_pkg.sv */
// Package of constants and types for the ignition auto switch-off sequencer
// Overview of operation
// [R1] At power-up check temperature and self-test before releasing host boot.
// [R2] Ignore temperature and ignition for the first three minutes after start-up.
// [R3] After masking, watch temperature and ignition continuously while running.
// [R4] Critical temperature: request host shutdown, keep power off until temperature permitted.
// [R5] Ignition low or floating: enter delay state, host stays powered until delay ends.
// [R6] Ignition returning during delay cancels it and resumes normal operation.
// [R7] Delay expiry signals host shutdown; cut power after shutdown time or host done.
// [R8] Host exchange uses two consecutive I/O ports at control_port_first and control_port_second.
// [R9] Settings come over serial configuration port; runtime traffic over parallel port.
// [R10] Without host software, power is removed after delay plus shutdown time.
// [R11] Delay and shutdown times are tick counts; delay reloads on each entry.
`default_nettype none
package iaso_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // Start-up mask, three minutes in ticks of one second
  localparam int unsigned MASK_MIN = 3;
  localparam logic [15:0] MASK_TICKS = 16'(MASK_MIN * 60 * 1000 / TICK_MS);
  // Reset values of programmable times, 15 and 3 minutes
  localparam logic [15:0] DELAY_RST = 16'h0384;
  localparam logic [15:0] SHUT_RST = 16'h00b4;
  // Port addresses
  localparam logic [9:0] ADDR_STATUS = 10'h379;
  localparam logic [9:0] ADDR_CTRL = 10'h37a;
  // Status port bit positions
  localparam int unsigned ST_SHUT_REQ = 0;
  localparam int unsigned ST_DELAY = 1;
  localparam int unsigned ST_HOT = 2;
  localparam int unsigned ST_MASK = 3;
  localparam int unsigned ST_IGN = 4;
  // Control port bit positions
  localparam int unsigned CT_DONE = 0;
  localparam int unsigned CT_ALIVE = 1;
  // Serial configuration
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BAUD_CYC = CLK_HZ / BAUD;
  localparam logic [7:0] CMD_DELAY = 8'h44;
  localparam logic [7:0] CMD_SHUT = 8'h53;
  typedef enum logic [2:0] {IASO_CHECK, IASO_MASK, IASO_RUN, IASO_DELAY, IASO_SHUT, IASO_OFF, IASO_HOT}
    iaso_state_t;
endpackage : iaso_pkg
`default_nettype wire

/* File: design/iaso_sync.sv */
// Two flip-flop synchroniser for one pin level
`default_nettype none
module iaso_sync (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Level in and out
  input wire logic d_i,
  output logic q_o
);
  logic meta;
  // First stage feeds only the second
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : iaso_sync
`default_nettype wire

/* File: design/iaso_uart_rx.sv */
// Serial byte receiver for the configuration port, 8N1
`default_nettype none
module iaso_uart_rx #(
  parameter int unsigned BIT_CYC = 10417
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Synchronised serial line
  input wire logic rxd_i,
  // Received byte, one-cycle strobe
  output logic [7:0] data_o,
  output logic valid_o
);
  logic [15:0] cnt;
  logic [3:0] bitn;
  logic busy;
  // Sample mid-bit; a false start bit is dropped
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 16'h0000;
      bitn <= 4'h0;
      busy <= 1'b0;
      data_o <= 8'h00;
      valid_o <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      if (!busy) begin
        if (!rxd_i) begin
          busy <= 1'b1;
          cnt <= 16'(BIT_CYC / 2);
          bitn <= 4'h0;
        end
      end else if (cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end else begin
        cnt <= 16'(BIT_CYC - 1);
        bitn <= bitn + 4'h1;
        if (bitn == 4'h0) begin
          if (rxd_i) begin
            busy <= 1'b0;
          end
        end else if (bitn == 4'h9) begin
          busy <= 1'b0;
          valid_o <= rxd_i;
        end else begin
          data_o <= {rxd_i, data_o[7:1]};
        end
      end
    end
  end
endmodule : iaso_uart_rx
`default_nettype wire

/* File: testbench/iaso_host.sv */
// Host PC model that drives the parallel control port of the sequencer
`default_nettype none
module iaso_host (
  // Clock
  input wire logic mclk_i,
  // Parallel I/O cycle towards the device
  output logic [9:0] io_addr_o,
  output logic io_rd_o,
  output logic io_wr_o,
  output logic [7:0] io_wdata_o,
  input wire logic [7:0] io_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    io_addr_o = 10'h000;
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
    io_wdata_o = 8'h00;
  end
  // One strobed access; strobe held five edges, then four low edges before the next
  task automatic cycle(input logic [9:0] addr, input logic wr, input logic [7:0] wdata, output logic [7:0] rdata);
    @(negedge mclk_i);
    io_addr_o = addr;
    io_wdata_o = wdata;
    io_rd_o = ~wr;
    io_wr_o = wr;
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    rdata = io_rdata_i;
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
    // Released lines flip so a stale level is never mistaken for a fresh one
    io_addr_o = ~io_addr_o;
    io_wdata_o = ~io_wdata_o;
    repeat (4) @(negedge mclk_i);
  endtask : cycle
endmodule : iaso_host
`default_nettype wire

/* File: testbench/tb_ignition_auto_switch_off.sv */
// Self-checking bench for the ignition auto switch-off sequencer
`default_nettype none
module tb_ignition_auto_switch_off;
  timeunit 1ns;
  timeprecision 1ps;
  import iaso_pkg::*;
  // Short tick and bit time keep the minute counts and serial frames inside the run
  localparam int TK = 10;
  localparam int BC = 20;
  localparam int LIMIT = 80000;
  logic mclk_i, rst_n_i, ign_i, temp_crit_i, self_ok_i, cfg_rxd_i;
  logic io_rd_i, io_wr_i, pwr_en_o, boot_en_o;
  logic [9:0] io_addr_i;
  logic [7:0] io_wdata_i, io_rdata_o;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int m_ign = 1;
  iaso_top #(.TICK_CYCLES(TK), .BIT_CYCLES(BC)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ign_i(ign_i),
    .temp_crit_i(temp_crit_i), .self_ok_i(self_ok_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
    .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .cfg_rxd_i(cfg_rxd_i),
    .pwr_en_o(pwr_en_o), .boot_en_o(boot_en_o));
  iaso_host u_host (.mclk_i(mclk_i), .io_addr_o(io_addr_i), .io_rd_o(io_rd_i), .io_wr_o(io_wr_i),
    .io_wdata_o(io_wdata_i), .io_rdata_i(io_rdata_o));
  // Clock, 100 MHz
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // Expected status byte from the bench's own view of the sequencer
  function automatic logic [7:0] st(input int sh, input int dl, input int ht, input int mk);
    return 8'((sh << ST_SHUT_REQ) | (dl << ST_DELAY) | (ht << ST_HOT) | (mk << ST_MASK) | (m_ign << ST_IGN));
  endfunction : st
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic ticks(input int n);
    repeat (n * TK) @(negedge mclk_i);
  endtask : ticks
  task automatic ign(input int b);
    ign_i = b[0];
    m_ign = b;
  endtask : ign
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    u_host.cycle(a, 1'b0, 8'h00, d);
  endtask : rd
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    logic [7:0] unused;
    u_host.cycle(a, 1'b1, v, unused);
  endtask : wr
  task automatic pw(input int e, input string what);
    chk(8'(pwr_en_o), 8'(e), what);
  endtask : pw
  // Serial byte, 8N1, least significant bit first, one bit every BC cycles
  task automatic ser(input logic [7:0] b);
    cfg_rxd_i = 1'b0;
    repeat (BC) @(negedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      cfg_rxd_i = b[i];
      repeat (BC) @(negedge mclk_i);
    end
    cfg_rxd_i = 1'b1;
    repeat (BC) @(negedge mclk_i);
  endtask : ser
  // Setting frame: command byte, then low and high byte of the tick count
  task automatic cfg(input logic [7:0] cmd, input logic [15:0] val);
    ser(cmd);
    ser(val[7:0]);
    ser(val[15:8]);
  endtask : cfg
  // Hang guard: counts as a mismatch and closes the run
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      conclude();
    end
  end
  // Main sequence
  initial begin
    logic [7:0] d, v;
    logic [15:0] dl;
    rst_n_i = 1'b0;
    ign_i = 1'b1;
    temp_crit_i = 1'b0;
    self_ok_i = 1'b0;
    cfg_rxd_i = 1'b1;
    void'($urandom(10895));
    repeat (3) @(negedge mclk_i);
    chk({6'h00, pwr_en_o, boot_en_o}, 8'h00, "outputs in reset");
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    ticks(5);
    chk({6'h00, pwr_en_o, boot_en_o}, 8'h00, "boot held without self test");
    self_ok_i = 1'b1;
    ticks(2);
    chk(8'(boot_en_o), 8'h01, "boot released");
    $display("test start done");
    // Ignition and heat are ignored while masking
    ticks(20);
    ign(0);
    ticks(3);
    rd(ADDR_STATUS, d);
    chk(d, st(0, 0, 0, 1), "status in mask, ignition off");
    ign(1);
    temp_crit_i = 1'b1;
    ticks(20);
    pw(1, "power during masked heat");
    temp_crit_i = 1'b0;
    ticks(150);
    rd(ADDR_STATUS, d);
    chk(d, st(0, 0, 0, 0), "status running");
    $display("test mask done");
    // Delay entry, cancel, reload; refused and stored control writes
    ign(0);
    ticks(5);
    rd(ADDR_STATUS, d);
    chk(d, st(0, 1, 0, 0), "delay running");
    ticks(500);
    ign(1);
    ticks(5);
    rd(ADDR_STATUS, d);
    chk(d, st(0, 0, 0, 0), "delay cancelled");
    v = 8'($urandom);
    wr(ADDR_CTRL, v);
    pw(1, "done write outside shutdown");
    rd(ADDR_CTRL, d);
    chk(d, {6'h00, v[CT_ALIVE], 1'b0}, "control readback");
    rd(10'h378, d);
    chk(d, 8'h00, "unmapped read");
    ign(0);
    ticks(600);
    pw(1, "power after reloaded delay");
    ign(1);
    ticks(5);
    $display("test delay done");
    // Delay expiry asks the host, host done cuts power early
    ign(0);
    ticks(880);
    rd(ADDR_STATUS, d);
    chk(d, st(0, 1, 0, 0), "delay before expiry");
    ticks(40);
    rd(ADDR_STATUS, d);
    chk(d, st(1, 0, 0, 0), "shutdown requested");
    pw(1, "power while host shuts down");
    wr(ADDR_CTRL, 8'h01);
    ticks(1);
    pw(0, "power cut on host done");
    ign(1);
    ticks(2);
    pw(1, "power restored by ignition");
    ticks(200);
    $display("test host shutdown done");
    // Critical heat shuts down and holds power off until cool
    temp_crit_i = 1'b1;
    ticks(5);
    rd(ADDR_STATUS, d);
    chk(d, st(0, 0, 1, 0), "hot status");
    ticks(190);
    pw(0, "power off when hot");
    ticks(50);
    pw(0, "power held off while hot");
    temp_crit_i = 1'b0;
    ticks(2);
    pw(1, "power back when cool");
    ticks(200);
    $display("test heat done");
    // No host answer: hard off after delay plus shutdown time
    ign(0);
    ticks(1060);
    pw(1, "power before hard off");
    ticks(40);
    pw(0, "hard off without host");
    $display("test hard off done");
    // Serial settings: a stray byte is ignored, new times apply on the next entry
    ign(1);
    ser(8'h12);
    dl = 16'(60 + $urandom % 64);
    cfg(CMD_DELAY, dl);
    cfg(CMD_SHUT, 16'h001e);
    ticks(200);
    ign(0);
    ticks(int'(dl) - 5);
    rd(ADDR_STATUS, d);
    chk(d, st(0, 1, 0, 0), "delay with serial time");
    ticks(10);
    rd(ADDR_STATUS, d);
    chk(d, st(1, 0, 0, 0), "shutdown after serial delay");
    ticks(30);
    pw(0, "hard off after serial shutdown time");
    $display("test serial settings done");
    conclude();
  end
endmodule : tb_ignition_auto_switch_off
`default_nettype wire
